// ===== shared/qlo_map.svh
// Register map, field positions, reset values and clock ratios for the LO synthesizer control.
`ifndef QLO_MAP_SVH
`define QLO_MAP_SVH
// ==========================================
// Register byte addresses
`define QLO_ADDR_CTRL 8'h00
`define QLO_ADDR_LO_WORD 8'h04
`define QLO_ADDR_TEST_WORD 8'h08
`define QLO_ADDR_STATUS 8'h0c
`define QLO_ADDR_MCLK_COUNT 8'h10
`define QLO_ADDR_USB_COUNT 8'h14
`define QLO_ADDR_CPU_COUNT 8'h18
`define QLO_ADDR_REF_COUNT 8'h1c
// ==========================================
// Control and status fields
`define QLO_CTRL_TX 0
`define QLO_CTRL_TEST 1
`define QLO_CTRL_LO 2
`define QLO_CTRL_MASK 8'h07
`define QLO_CTRL_RST 8'h04
`define QLO_WORD_RST 32'h0000_0000
`define QLO_STAT_TX 0
`define QLO_STAT_TEST 1
`define QLO_STAT_LO 2
// ==========================================
// AXI responses
`define QLO_RESP_OKAY 2'h0
`define QLO_RESP_SLVERR 2'h2
// ==========================================
// Derived clock ratios in 16.16 fixed point
`define QLO_REF_KHZ 64'd25000
`define QLO_MCLK_FS 64'd512
`define QLO_FS_KHZ 64'd48
`define QLO_MCLK_KHZ (`QLO_MCLK_FS * `QLO_FS_KHZ)
`define QLO_USB_KHZ 64'd48000
`define QLO_CPU_KHZ 64'd72000
`define QLO_FRAC_ONE 64'd65536
`define QLO_STEP(khz) ((khz) * `QLO_FRAC_ONE / `QLO_REF_KHZ)
`endif

// ===== shared/qlo_pkg.sv
// Types shared by the LO synthesizer control.
`default_nettype none
package qlo_pkg;
    typedef enum {QLO_RX, QLO_TX} qlo_mode_t;
    typedef enum {QLO_WR_IDLE, QLO_WR_RESP} qlo_wr_state_t;
    typedef logic [1:0] qlo_resp_t;
endpackage : qlo_pkg
`default_nettype wire

// ===== logic/qlo_synth.sv
// LO synthesizer control with AXI4-Lite register access.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "qlo_map.svh"
// ==========================================
// Overview of operation
// - Two independently programmable frequencies on three outputs; both LO outputs share one word.
// - Two accumulators multiply; three outputs divide down.
// - Controller programs configuration registers over bus.
// - Receive: outputs in glitch-free quadrature.
// - Transmit: outputs run in antiphase.
// - Test output only with receive LO.
// - Converter master clock is 512 times fs.
// - USB and processor clocks from reference.
module qlo_synth (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ref_clk_pin,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic lo_output_a,
    output logic lo_output_b,
    output logic test_generator_output
);
    // ==========================================
    // Reference synchroniser and edge detect.
    logic ref_s1_reg;
    logic ref_s2_reg;
    logic ref_s3_reg;
    logic ref_rise;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_s3_reg <= 1'b0;
        end else begin
            ref_s1_reg <= ref_clk_pin;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
        end
    end
    assign ref_rise = ref_s2_reg & ~ref_s3_reg;

    // ==========================================
    // Write channel.
    logic [7:0] ctrl_reg;
    logic [31:0] lo_word_reg;
    logic [31:0] test_word_reg;
    logic [7:0] aw_addr_reg;
    logic aw_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_full_reg;
    qlo_pkg::qlo_wr_state_t wr_state_reg;
    qlo_pkg::qlo_resp_t bresp_next;
    logic wr_fire;
    assign wr_fire = aw_full_reg && w_full_reg && (wr_state_reg == qlo_pkg::QLO_WR_IDLE);

    always_comb begin
        case (aw_addr_reg)
            `QLO_ADDR_CTRL, `QLO_ADDR_LO_WORD, `QLO_ADDR_TEST_WORD: bresp_next = `QLO_RESP_OKAY;
            default: bresp_next = `QLO_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full_reg && (wr_state_reg == qlo_pkg::QLO_WR_IDLE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end else begin
            s_axi_wready <= !w_full_reg && (wr_state_reg == qlo_pkg::QLO_WR_IDLE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= qlo_pkg::QLO_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `QLO_RESP_OKAY;
        end else begin
            case (wr_state_reg)
                qlo_pkg::QLO_WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_reg <= qlo_pkg::QLO_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= bresp_next;
                    end
                end
                qlo_pkg::QLO_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_reg <= qlo_pkg::QLO_WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: wr_state_reg <= qlo_pkg::QLO_WR_IDLE;
            endcase
        end
    end

    // Register file; byte lanes honoured.
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    lo_word_reg[gb*8 +: 8] <= 8'(`QLO_WORD_RST);
                    test_word_reg[gb*8 +: 8] <= 8'(`QLO_WORD_RST);
                end else if (wr_fire && w_strb_reg[gb]) begin
                    if (aw_addr_reg == `QLO_ADDR_LO_WORD) begin
                        lo_word_reg[gb*8 +: 8] <= w_data_reg[gb*8 +: 8];
                    end
                    if (aw_addr_reg == `QLO_ADDR_TEST_WORD) begin
                        test_word_reg[gb*8 +: 8] <= w_data_reg[gb*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `QLO_CTRL_RST;
        end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == `QLO_ADDR_CTRL) begin
            ctrl_reg <= w_data_reg[7:0] & `QLO_CTRL_MASK;
        end
    end

    // ==========================================
    // Synthesis: settings take effect on reference edges only.
    qlo_pkg::qlo_mode_t mode_reg;
    logic lo_en_reg;
    logic test_en_reg;
    logic [31:0] lo_phase_reg;
    logic [31:0] test_phase_reg;
    logic [31:0] ref_count_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= qlo_pkg::QLO_RX;
            lo_en_reg <= 1'b0;
            test_en_reg <= 1'b0;
        end else if (ref_rise) begin
            mode_reg <= ctrl_reg[`QLO_CTRL_TX] ? qlo_pkg::QLO_TX : qlo_pkg::QLO_RX;
            lo_en_reg <= ctrl_reg[`QLO_CTRL_LO];
            test_en_reg <= ctrl_reg[`QLO_CTRL_TEST] && ctrl_reg[`QLO_CTRL_LO]
                && !ctrl_reg[`QLO_CTRL_TX];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_phase_reg <= 32'h0000_0000;
            test_phase_reg <= 32'h0000_0000;
            ref_count_reg <= 32'h0000_0000;
        end else if (ref_rise) begin
            ref_count_reg <= ref_count_reg + 32'h0000_0001;
            if (lo_en_reg) begin
                lo_phase_reg <= lo_phase_reg + lo_word_reg;
            end
            if (test_en_reg) begin
                test_phase_reg <= test_phase_reg + test_word_reg;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_output_a <= 1'b0;
            lo_output_b <= 1'b0;
            test_generator_output <= 1'b0;
        end else begin
            lo_output_a <= lo_en_reg && lo_phase_reg[31];
            if (!lo_en_reg) begin
                lo_output_b <= 1'b0;
            end else if (mode_reg == qlo_pkg::QLO_TX) begin
                lo_output_b <= !lo_phase_reg[31];
            end else begin
                lo_output_b <= lo_phase_reg[31] ^ lo_phase_reg[30];
            end
            test_generator_output <= test_en_reg && test_phase_reg[31];
        end
    end

    // Converter master, USB and processor clock cycle counters.
    localparam logic [31:0] DERIVED_STEP [3] = '{
        32'(`QLO_STEP(`QLO_MCLK_KHZ)),
        32'(`QLO_STEP(`QLO_USB_KHZ)),
        32'(`QLO_STEP(`QLO_CPU_KHZ))
    };
    logic [31:0] derived_acc_reg [3];
    genvar gd;
    generate
        for (gd = 0; gd < 3; gd++) begin : g_derived
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    derived_acc_reg[gd] <= 32'h0000_0000;
                end else if (ref_rise) begin
                    derived_acc_reg[gd] <= derived_acc_reg[gd] + DERIVED_STEP[gd];
                end
            end
        end
    endgenerate

    // ==========================================
    // Read channel.
    logic [31:0] rdata_next;
    qlo_pkg::qlo_resp_t rresp_next;
    always_comb begin
        rresp_next = `QLO_RESP_OKAY;
        rdata_next = 32'h0000_0000;
        case (s_axi_araddr)
            `QLO_ADDR_CTRL: rdata_next = {24'h00_0000, ctrl_reg};
            `QLO_ADDR_LO_WORD: rdata_next = lo_word_reg;
            `QLO_ADDR_TEST_WORD: rdata_next = test_word_reg;
            `QLO_ADDR_STATUS: begin
                rdata_next[`QLO_STAT_TX] = (mode_reg == qlo_pkg::QLO_TX);
                rdata_next[`QLO_STAT_TEST] = test_en_reg;
                rdata_next[`QLO_STAT_LO] = lo_en_reg;
            end
            `QLO_ADDR_MCLK_COUNT: rdata_next = {16'h0000, derived_acc_reg[0][31:16]};
            `QLO_ADDR_USB_COUNT: rdata_next = {16'h0000, derived_acc_reg[1][31:16]};
            `QLO_ADDR_CPU_COUNT: rdata_next = {16'h0000, derived_acc_reg[2][31:16]};
            `QLO_ADDR_REF_COUNT: rdata_next = ref_count_reg;
            default: rresp_next = `QLO_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `QLO_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    // ==========================================
    // Assertions.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_taken;
        wr_fire;
    endsequence
    sequence s_resp_shown;
        s_axi_bvalid && wr_state_reg == qlo_pkg::QLO_WR_RESP;
    endsequence

    property p_tx_antiphase;
        lo_en_reg && mode_reg == qlo_pkg::QLO_TX |=> lo_output_b == !lo_output_a;
    endproperty
    a_tx_antiphase: assert property (p_tx_antiphase) else $error("tx outputs not in antiphase");
    property p_rx_quadrature;
        lo_en_reg && mode_reg == qlo_pkg::QLO_RX |=> lo_output_b == ($past(lo_phase_reg[31])
            ^ $past(lo_phase_reg[30]));
    endproperty
    a_rx_quadrature: assert property (p_rx_quadrature) else $error("rx quadrature broken");
    property p_test_off;
        !test_en_reg |=> !test_generator_output;
    endproperty
    a_test_off: assert property (p_test_off) else $error("test output active while off");
    property p_test_with_rx;
        test_en_reg |-> lo_en_reg && mode_reg == qlo_pkg::QLO_RX;
    endproperty
    a_test_with_rx: assert property (p_test_with_rx) else $error("test output without rx lo");
    property p_lo_step;
        ref_rise && lo_en_reg |=> lo_phase_reg == $past(lo_phase_reg) + $past(lo_word_reg);
    endproperty
    a_lo_step: assert property (p_lo_step) else $error("lo phase step wrong");
    property p_hold_between_edges;
        !ref_rise |=> $stable(lo_phase_reg) && $stable(mode_reg);
    endproperty
    a_hold_between_edges: assert property (p_hold_between_edges) else $error("phase moved");
    property p_mclk_step;
        ref_rise |=> derived_acc_reg[0] == $past(derived_acc_reg[0]) + DERIVED_STEP[0];
    endproperty
    a_mclk_step: assert property (p_mclk_step) else $error("master clock count wrong");
    property p_write_resp;
        s_write_taken |=> s_resp_shown;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("no write response");
    property p_rdata_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
endmodule : qlo_synth
`default_nettype wire

// ===== tb/qlo_ref_osc.sv
// Reference oscillator model that drives the synthesizer reference pin.
`timescale 1ns/10ps
`default_nettype none
module qlo_ref_osc #(
    parameter real HALF_NS = 62.5
) (
    output logic ref_clk_pin
);
    // ==========================================
    // Free-running source, offset so its edges never meet the bus clock.
    initial begin
        ref_clk_pin = 1'b0;
        #3.3;
        forever #(HALF_NS) ref_clk_pin = ~ref_clk_pin;
    end
endmodule : qlo_ref_osc
`default_nettype wire

// ===== tb/quadrature_lo_synth_control_bench.sv
// Self-checking bench for the LO synthesizer control.
`timescale 1ns/10ps
`default_nettype none
`include "qlo_map.svh"
module quadrature_lo_synth_control_bench;
    logic aclk, aresetn, ref_clk_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic lo_output_a, lo_output_b, test_generator_output, la, lb, lt;
    int n_errors = 0;
    int checks = 0;
    int cnt [6] = '{0, 0, 0, 0, 0, 0};
    int d [6];
    logic [31:0] exp_d [$];
    logic [31:0] exp_m [$];
    logic [1:0] exp_r [$];
    logic [1:0] exp_b [$];
    logic [31:0] seed = 32'h0dd6c4d5;
    qlo_synth dut_u (
        .aclk(aclk),
        .aresetn(aresetn),
        .ref_clk_pin(ref_clk_pin),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .lo_output_a(lo_output_a),
        .lo_output_b(lo_output_b),
        .test_generator_output(test_generator_output)
    );
    qlo_ref_osc osc_u (.ref_clk_pin(ref_clk_pin));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ==========================================
    // Shared tasks.
    task automatic finish_test;
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, want, seen);
        end
    endtask : check
    function automatic logic near(input int v, input int e, input int t);
        return v >= e - t && v <= e + t;
    endfunction : near
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction : lfsr
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b0;
        end while (s_axi_bready === 1'b1 && n < 200);
        if (n >= 200) begin
            n_errors++;
            finish_test();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
                      input logic [1:0] r, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge aclk);
        exp_d.push_back(v);
        exp_m.push_back(m);
        exp_r.push_back(r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                q = s_axi_rdata;
                s_axi_rready <= 1'b0;
            end
        end while (s_axi_rready === 1'b1 && n < 200);
        if (n >= 200) begin
            n_errors++;
            finish_test();
        end
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] q;
        rd(a, v, 32'hffffffff, `QLO_RESP_OKAY, q);
    endtask : rc
    task automatic win(input int n);
        int s [6];
        s = cnt;
        repeat (n) @(posedge aclk);
        foreach (d[i]) d[i] = cnt[i] - s[i];
    endtask : win
    // ==========================================
    // Result watchers.
    always @(posedge aclk) begin : watch
        logic [31:0] mk;
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            check("bresp", s_axi_bresp, exp_b.pop_front());
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            mk = exp_m.pop_front();
            check("rdata", s_axi_rdata & mk, exp_d.pop_front() & mk);
            check("rresp", s_axi_rresp, exp_r.pop_front());
        end
        cnt[0] += (lo_output_a === 1'b1 && la === 1'b0);
        cnt[1] += (lo_output_b === 1'b1 && lb === 1'b0);
        cnt[2] += (test_generator_output === 1'b1 && lt === 1'b0);
        cnt[3] += (lo_output_a !== la && lo_output_b !== lb);
        cnt[4] += (lo_output_a === lo_output_b);
        cnt[5] += (lo_output_a === 1'b1 && la === 1'b0 && lo_output_b === 1'b1);
        la = lo_output_a;
        lb = lo_output_b;
        lt = test_generator_output;
    end
    // ==========================================
    // Main sequence.
    initial begin
        logic [31:0] v, r0, r1;
        logic [31:0] m0 [3];
        logic [31:0] m1 [3];
        longint st [3];
        int dr;
        st[0] = 64'd512 * 64'd48 * 64'd65536 / 64'd25000;
        st[1] = 64'd48000 * 64'd65536 / 64'd25000;
        st[2] = 64'd72000 * 64'd65536 / 64'd25000;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`QLO_ADDR_CTRL, 32'h4);
        rc(`QLO_ADDR_LO_WORD, 32'h0);
        repeat (100) @(posedge aclk);
        rc(`QLO_ADDR_STATUS, 32'h4);
        rd(8'h20, 32'h0, 32'hffffffff, `QLO_RESP_SLVERR, v);
        wr(8'h24, 32'h1, `QLO_RESP_SLVERR);
        v = lfsr();
        wr(`QLO_ADDR_TEST_WORD, v, `QLO_RESP_OKAY);
        rc(`QLO_ADDR_TEST_WORD, v);
        s_axi_wstrb <= 4'h3;
        wr(`QLO_ADDR_TEST_WORD, ~v, `QLO_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rc(`QLO_ADDR_TEST_WORD, {v[31:16], ~v[15:0]});
        v = lfsr();
        wr(`QLO_ADDR_LO_WORD, v, `QLO_RESP_OKAY);
        rc(`QLO_ADDR_LO_WORD, v);
        wr(`QLO_ADDR_LO_WORD, 32'h4000_0000, `QLO_RESP_OKAY);
        wr(`QLO_ADDR_TEST_WORD, 32'h2000_0000, `QLO_RESP_OKAY);
        wr(`QLO_ADDR_CTRL, 32'h6, `QLO_RESP_OKAY);
        repeat (100) @(posedge aclk);
        rc(`QLO_ADDR_STATUS, 32'h6);
        win(1000);
        check("a_rises", near(d[0], 20, 1), 1);
        check("b_rises", near(d[1], d[0], 1), 1);
        check("test_rises", near(d[2], 10, 1), 1);
        check("same_edge", d[3], 0);
        check("b_at_a", d[5] == 0 || d[5] == d[0], 1);
        wr(`QLO_ADDR_LO_WORD, 32'h2000_0000, `QLO_RESP_OKAY);
        win(1000);
        check("a_rises", near(d[0], 10, 2), 1);
        check("same_edge", d[3], 0);
        check("b_at_a", d[5] == 0 || d[5] == d[0], 1);
        wr(`QLO_ADDR_CTRL, 32'h7, `QLO_RESP_OKAY);
        repeat (100) @(posedge aclk);
        rc(`QLO_ADDR_STATUS, 32'h5);
        win(500);
        check("tx_equal", d[4], 0);
        check("tx_a_rises", near(d[0], 5, 1), 1);
        check("tx_test_rises", d[2], 0);
        wr(`QLO_ADDR_CTRL, 32'h2, `QLO_RESP_OKAY);
        repeat (100) @(posedge aclk);
        rc(`QLO_ADDR_STATUS, 32'h0);
        win(500);
        check("off_test_rises", d[2], 0);
        wr(`QLO_ADDR_CTRL, 32'h4, `QLO_RESP_OKAY);
        rd(`QLO_ADDR_REF_COUNT, 32'h0, 32'h0, `QLO_RESP_OKAY, r0);
        for (int k = 0; k < 3; k++) rd(8'h10 + 8'(4 * k), 32'h0, 32'h0, `QLO_RESP_OKAY, m0[k]);
        repeat (2000) @(posedge aclk);
        rd(`QLO_ADDR_REF_COUNT, 32'h0, 32'h0, `QLO_RESP_OKAY, r1);
        for (int k = 0; k < 3; k++) rd(8'h10 + 8'(4 * k), 32'h0, 32'h0, `QLO_RESP_OKAY, m1[k]);
        dr = int'(r1 - r0);
        check("ref_edges", near(dr, 161, 3), 1);
        for (int k = 0; k < 3; k++) begin
            check("derived_count", near(int'((m1[k] - m0[k]) & 32'hffff), int'((dr * st[k]) >> 16),
                  int'(2 * (st[k] >> 16) + 3)), 1);
        end
        finish_test();
    end
endmodule : quadrature_lo_synth_control_bench
`default_nettype wire
